// [design/bfp_pkg.sv]
`default_nettype none

package bfp_pkg;

    // ********************************************************************
    // register map, byte addresses
    // ********************************************************************
    localparam int          ADDR_W         = 12;
    localparam logic [11:0] ADDR_FUSE      = 12'h6e0;  // serial flash config fuse word
    localparam logic [11:0] ADDR_STATUS    = 12'h6e4;
    localparam logic [11:0] ADDR_OFFSET    = 12'h6e8;
    localparam logic [11:0] ADDR_SIZE      = 12'h6ec;
    localparam logic [11:0] ADDR_CTRL      = 12'h6f0;

    // ********************************************************************
    // fuse word fields
    // ********************************************************************
    localparam int DUMMY_LSB   = 8;
    localparam int SIZE_LSB    = 12;
    localparam int OFFSET_LSB  = 16;
    localparam int TYPE_LSB    = 2;                    // within boot config byte 1

    // ********************************************************************
    // status and control fields
    // ********************************************************************
    localparam int ST_VALID    = 0;
    localparam int ST_FUSEMODE = 1;
    localparam int ST_PROBE    = 2;
    localparam int ST_TYPE_LSB = 3;
    localparam int ST_REMAP    = 5;
    localparam int ST_DAUTO    = 6;
    localparam int ST_DUM_LSB  = 8;
    localparam int ST_STRAP0   = 16;
    localparam int ST_STRAP1   = 17;
    localparam int ST_PSTRAP   = 18;
    localparam int ST_CHANGED  = 24;
    localparam int ST_DONE     = 31;
    localparam int CTRL_DONE   = 0;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // ********************************************************************
    // sizes and timing
    // ********************************************************************
    localparam int          BYTES_W     = 26;          // 255 * 256 KB fits in 26 bits
    localparam int          SEG_SHIFT   = 18;          // 256 KB
    localparam int          MB_SHIFT    = 20;          // 1 MB
    localparam logic [3:0]  SIZE_MB_MAX = 4'hc;
    localparam logic [1:0]  SETTLE_CNT  = 2'h3;        // synchroniser fill before capture

    typedef enum logic [1:0] {
        FT_QUAD_NOR, FT_OCTAL_A, FT_OCTAL_B, FT_OCTAL_C
    } bfp_ftype_t;

    // decoded settings handed to the serial boot path
    typedef struct packed {
        logic               valid;
        logic               fuseMode;
        logic               autoProbe;
        bfp_ftype_t         flashType;
        logic               remapEn;
        logic [BYTES_W-1:0] secImageOffset;
        logic [BYTES_W-1:0] imageSize;
        logic               dummyAuto;
        logic [3:0]         dummyCycles;
    } bfp_cfg_t;

    // raw boot-time inputs
    typedef struct packed {
        logic        autoProbeFuse;
        logic        bootFuseSelect;
        logic [7:0]  bootConfigByte1;
        logic [31:0] fuseWord;
    } bfp_fuse_t;

    // remap offset field to bytes
    function automatic logic [BYTES_W-1:0] offsetBytes(input logic [7:0] field);
        offsetBytes = BYTES_W'({field, SEG_SHIFT'(0)});
    endfunction : offsetBytes

    // image size field to bytes
    function automatic logic [BYTES_W-1:0] sizeBytes(input logic [3:0] field,
                                                     input logic [7:0] offs);
        logic [3:0] quarters;
        quarters = field - SIZE_MB_MAX;
        if (field == 4'h0) begin
            sizeBytes = offsetBytes(offs);
        end else if (field <= SIZE_MB_MAX) begin
            sizeBytes = BYTES_W'({field, MB_SHIFT'(0)});
        end else begin
            sizeBytes = BYTES_W'({quarters, SEG_SHIFT'(0)});
        end
    endfunction : sizeBytes

endpackage : bfp_pkg

`default_nettype wire

// [design/bfp_sync.sv]
`timescale 1ns/10ps
`default_nettype none

module bfp_sync
    import bfp_pkg::*;
#(
    parameter int W = 3
) (
    input  wire logic         ref_clk,  // system clock
    input  wire logic         srst,     // synchronous reset
    input  wire logic [W-1:0] pinIn,    // asynchronous pin levels
    output logic      [W-1:0] syncOut   // levels in the clock domain
);

    logic [W-1:0] stage1;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_syncOut;

    // first stage feeds only the second
    always_comb begin
        next_stage1  = pinIn;
        next_syncOut = stage1;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            stage1  <= '0;
            syncOut <= '0;
        end else begin
            stage1  <= next_stage1;
            syncOut <= next_syncOut;
        end
    end

endmodule : bfp_sync

`default_nettype wire

// [design/bfp_decode.sv]
`timescale 1ns/10ps
`default_nettype none

module bfp_decode
    import bfp_pkg::*;
(
    input  wire logic      probeStrap,  // synchronised probe enable strap
    input  wire logic      typeStrap0,  // synchronised flash type strap 0
    input  wire logic      typeStrap1,  // synchronised flash type strap 1
    input  wire bfp_fuse_t fuse,        // fuse values
    output bfp_cfg_t       cfg          // decoded settings, combinational
);

    logic [7:0] offField;
    logic [3:0] sizeField;
    logic [3:0] dumField;

    // purely combinational; the top registers the result once
    always_comb begin
        offField  = fuse.fuseWord[OFFSET_LSB +: 8];
        sizeField = fuse.fuseWord[SIZE_LSB +: 4];
        dumField  = fuse.fuseWord[DUMMY_LSB +: 4];
        cfg       = '0;
        cfg.valid    = 1'b1;
        cfg.fuseMode = fuse.bootFuseSelect;
        if (fuse.bootFuseSelect) begin
            cfg.autoProbe = fuse.autoProbeFuse & fuse.bootFuseSelect;
            cfg.flashType = bfp_ftype_t'(fuse.bootConfigByte1[TYPE_LSB +: 2]);
        end else begin
            cfg.autoProbe = probeStrap;
            cfg.flashType = bfp_ftype_t'({typeStrap1, typeStrap0});
        end
        cfg.remapEn        = (offField != 8'h00);
        cfg.secImageOffset = offsetBytes(offField);
        cfg.imageSize      = sizeBytes(sizeField, offField);
        cfg.dummyAuto      = (dumField == 4'h0);
        cfg.dummyCycles    = dumField;
    end

endmodule : bfp_decode

`default_nettype wire

// [design/bfp_top.sv]
`timescale 1ns/10ps
`default_nettype none

module bfp_top
    import bfp_pkg::*;
(
    input  wire logic              ref_clk,          // 25 MHz system clock
    input  wire logic              srst,             // synchronous reset, active high
    // boot-time sources
    input  wire logic              autoProbeFuse,    // auto-probe enable fuse
    input  wire logic              boot_fuse_select, // boot configuration from fuses
    input  wire logic [7:0]        boot_config_byte1,// boot configuration byte 1
    input  wire logic [31:0]       fuseWord,         // serial flash config fuse word
    input  wire logic              probe_enable_strap, // pin: request auto-probe
    input  wire logic              flash_type_strap0,  // pin: flash type bit 0
    input  wire logic              flash_type_strap1,  // pin: flash type bit 1
    // settings to the serial boot path
    output bfp_cfg_t               cfg,              // decoded settings
    output logic                   bootDone,         // software marks boot done
    // apb slave
    input  wire logic              psel,             // select
    input  wire logic              penable,          // access phase
    input  wire logic              pwrite,           // write when high
    input  wire logic [ADDR_W-1:0] paddr,            // byte address
    input  wire logic [31:0]       pwdata,           // write data
    input  wire logic [3:0]        pstrb,            // byte strobes
    output logic                   pready,           // transfer done
    output logic [31:0]            prdata,           // read data
    output logic                   pslverr           // error answer
);

    // ********************************************************************
    // pin synchronisers
    // ********************************************************************
    logic [2:0] strapSync;

    // straps are board pins, so two flops before anything looks at them
    bfp_sync #(
        .W (3)
    ) u_sync (
        .ref_clk (ref_clk),
        .srst    (srst),
        .pinIn   ({probe_enable_strap, flash_type_strap1, flash_type_strap0}),
        .syncOut (strapSync)
    );

    logic strap0Lvl;
    logic strap1Lvl;
    logic probeLvl;

    assign strap0Lvl = strapSync[0];
    assign strap1Lvl = strapSync[1];
    assign probeLvl  = strapSync[2];

    // ********************************************************************
    // decoder
    // ********************************************************************
    bfp_fuse_t fuseIn;
    bfp_cfg_t  decoded;

    assign fuseIn = '{autoProbeFuse:   autoProbeFuse,
                      bootFuseSelect:  boot_fuse_select,
                      bootConfigByte1: boot_config_byte1,
                      fuseWord:        fuseWord};

    bfp_decode u_decode (
        .probeStrap (probeLvl),
        .typeStrap0 (strap0Lvl),
        .typeStrap1 (strap1Lvl),
        .fuse       (fuseIn),
        .cfg        (decoded)
    );

    // ********************************************************************
    // one-shot capture sequencer
    // ********************************************************************
    typedef enum logic [1:0] {
        SEQ_SETTLE, SEQ_CAPTURE, SEQ_HOLD
    } bfp_seq_t;

    bfp_seq_t    seqState;
    bfp_seq_t    next_seqState;
    logic [1:0]  settleCnt;
    logic [1:0]  next_settleCnt;
    bfp_cfg_t    next_cfg;
    logic [31:0] fuseCopy;
    logic [31:0] next_fuseCopy;
    logic [2:0]  strapCopy;
    logic [2:0]  next_strapCopy;

    // wait for the synchronisers to hold real pin levels, then capture once;
    // fuse or strap changes later are ignored so the boot path sees one value
    always_comb begin
        next_seqState  = seqState;
        next_settleCnt = settleCnt;
        next_cfg       = cfg;
        next_fuseCopy  = fuseCopy;
        next_strapCopy = strapCopy;
        case (seqState)
            SEQ_SETTLE: begin
                if (settleCnt == SETTLE_CNT) begin
                    next_seqState = SEQ_CAPTURE;
                end else begin
                    next_settleCnt = settleCnt + 2'h1;
                end
            end
            SEQ_CAPTURE: begin
                next_cfg       = decoded;
                next_fuseCopy  = fuseWord;
                next_strapCopy = strapSync;
                next_seqState  = SEQ_HOLD;
            end
            SEQ_HOLD: begin
                next_seqState = SEQ_HOLD;
            end
            default: begin
                next_seqState = SEQ_SETTLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            seqState  <= SEQ_SETTLE;
            settleCnt <= 2'h0;
            cfg       <= '0;
            fuseCopy  <= RESET_WORD;
            strapCopy <= 3'h0;
        end else begin
            seqState  <= next_seqState;
            settleCnt <= next_settleCnt;
            cfg       <= next_cfg;
            fuseCopy  <= next_fuseCopy;
            strapCopy <= next_strapCopy;
        end
    end

    // ********************************************************************
    // strap watch
    // ********************************************************************
    logic strapChanged;
    logic next_strapChanged;
    logic strapEvent;
    logic chgClear;

    // straps moving after capture do not alter settings, but software is told;
    // a new change in the clearing cycle wins over the clear
    assign strapEvent = (seqState == SEQ_HOLD) && (strapSync != strapCopy);

    always_comb begin
        next_strapChanged = (strapChanged & ~chgClear) | strapEvent;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            strapChanged <= 1'b0;
        end else begin
            strapChanged <= next_strapChanged;
        end
    end

    // ********************************************************************
    // apb slave
    // ********************************************************************
    logic        accessReq;
    logic        accessDone;
    logic        wrDone;
    logic        next_pready;
    logic [31:0] next_prdata;
    logic        next_pslverr;
    logic        next_bootDone;
    logic [31:0] statusWord;

    // one wait state: pready rises in the second access cycle, and the write
    // lands on the edge where the master sees pready high
    assign accessReq  = psel && penable && !pready;
    assign accessDone = psel && penable && pready;
    assign wrDone     = accessDone && pwrite && !pslverr;
    assign chgClear   = wrDone && (paddr == ADDR_STATUS) && pstrb[ST_CHANGED / 8]
                        && pwdata[ST_CHANGED];

    // live status view
    always_comb begin
        statusWord                          = 32'h0000_0000;
        statusWord[ST_VALID]                = cfg.valid;
        statusWord[ST_FUSEMODE]             = cfg.fuseMode;
        statusWord[ST_PROBE]                = cfg.autoProbe;
        statusWord[ST_TYPE_LSB +: 2]        = cfg.flashType;
        statusWord[ST_REMAP]                = cfg.remapEn;
        statusWord[ST_DAUTO]                = cfg.dummyAuto;
        statusWord[ST_DUM_LSB +: 4]         = cfg.dummyCycles;
        statusWord[ST_STRAP0]               = strap0Lvl;
        statusWord[ST_STRAP1]               = strap1Lvl;
        statusWord[ST_PSTRAP]               = probeLvl;
        statusWord[ST_CHANGED]              = strapChanged;
        statusWord[ST_DONE]                 = bootDone;
    end

    // answer decode; writes to read-only words and any access to an unmapped address are errors
    always_comb begin
        next_pready  = 1'b0;
        next_prdata  = prdata;
        next_pslverr = 1'b0;
        if (accessReq) begin
            next_pready = 1'b1;
            next_prdata = 32'h0000_0000;
            if (paddr == ADDR_FUSE) begin
                next_prdata  = fuseCopy;
                next_pslverr = pwrite;
            end else if (paddr == ADDR_STATUS) begin
                next_prdata  = statusWord;
            end else if (paddr == ADDR_OFFSET) begin
                next_prdata  = 32'(cfg.secImageOffset);
                next_pslverr = pwrite;
            end else if (paddr == ADDR_SIZE) begin
                next_prdata  = 32'(cfg.imageSize);
                next_pslverr = pwrite;
            end else if (paddr == ADDR_CTRL) begin
                next_prdata  = {31'h0000_0000, bootDone};
            end else begin
                next_pslverr = 1'b1;
            end
        end
    end

    // control bit handed straight to the boot path
    always_comb begin
        next_bootDone = bootDone;
        if (wrDone && (paddr == ADDR_CTRL) && pstrb[CTRL_DONE / 8]) begin
            next_bootDone = pwdata[CTRL_DONE];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pready   <= 1'b0;
            prdata   <= 32'h0000_0000;
            pslverr  <= 1'b0;
            bootDone <= 1'b0;
        end else begin
            pready   <= next_pready;
            prdata   <= next_prdata;
            pslverr  <= next_pslverr;
            bootDone <= next_bootDone;
        end
    end

endmodule : bfp_top

`default_nettype wire

// [dv/bfp_top_properties.sv]
`timescale 1ns/10ps
`default_nettype none

module bfp_top_properties
    import bfp_pkg::*;
(
    input wire logic        ref_clk,            // system clock
    input wire logic        srst,               // synchronous reset
    input wire logic        autoProbeFuse,      // probe fuse
    input wire logic        boot_fuse_select,   // fuse mode select
    input wire logic [7:0]  boot_config_byte1,  // boot config byte 1
    input wire logic [31:0] fuseWord,           // serial flash fuse word
    input wire logic        probe_enable_strap, // probe strap pin
    input wire logic        flash_type_strap0,  // type strap 0
    input wire logic        flash_type_strap1,  // type strap 1
    input wire bfp_cfg_t    cfg,                // decoded settings
    input wire logic        psel,               // apb select
    input wire logic        penable,            // apb access phase
    input wire logic        pready              // apb answer
);
    // ****************************************************************
    // expected image size and properties
    // ****************************************************************
    logic [25:0] expSize;

    // built from shifts, not from the package helper, so a shared slip shows
    always_comb begin
        if (fuseWord[15:12] == 4'h0) begin
            expSize = {fuseWord[23:16], 18'h0};
        end else if (fuseWord[15:12] < 4'hd) begin
            expSize = {2'h0, fuseWord[15:12], 20'h0};
        end else begin
            expSize = {4'h0, fuseWord[15:12] - 4'hc, 18'h0};
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    capture_once_a: assert property ($fell(srst) |-> !cfg.valid [*3] ##[1:6] cfg.valid)
        else $error("settings not captured in time");
    held_stable_a: assert property (cfg.valid |=> $stable(cfg))
        else $error("settings moved after capture");
    fuse_probe_a: assert property ($rose(cfg.valid) && boot_fuse_select |->
        cfg.autoProbe == autoProbeFuse) else $error("fuse probe wrong");
    fuse_type_a: assert property ($rose(cfg.valid) && boot_fuse_select |->
        cfg.flashType == boot_config_byte1[3:2]) else $error("fuse flash type wrong");
    strap_probe_a: assert property ($rose(cfg.valid) && !boot_fuse_select |->
        cfg.autoProbe == probe_enable_strap) else $error("strap probe wrong");
    strap_type_a: assert property ($rose(cfg.valid) && !boot_fuse_select |->
        cfg.flashType == {flash_type_strap1, flash_type_strap0}) else $error("strap type wrong");
    image_offset_a: assert property ($rose(cfg.valid) |->
        cfg.secImageOffset == {fuseWord[23:16], 18'h0}) else $error("offset wrong");
    remap_enable_a: assert property ($rose(cfg.valid) |->
        cfg.remapEn == (fuseWord[23:16] != 8'h00)) else $error("remap enable wrong");
    image_size_a: assert property ($rose(cfg.valid) |-> cfg.imageSize == expSize)
        else $error("image size wrong");
    dummy_count_a: assert property ($rose(cfg.valid) |-> cfg.dummyCycles == fuseWord[11:8]
        && cfg.dummyAuto == (fuseWord[11:8] == 4'h0)) else $error("dummy count wrong");
    apb_answer_a: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer late");

    cover property ($rose(cfg.valid) && boot_fuse_select);
    cover property ($rose(cfg.valid) && !boot_fuse_select && cfg.autoProbe);
    cover property ($rose(cfg.valid) && cfg.remapEn);
endmodule : bfp_top_properties

`default_nettype wire

// [dv/bfp_boot_sink.sv]
`timescale 1ns/10ps
`default_nettype none

module bfp_boot_sink
    import bfp_pkg::*;
(
    input  wire logic     ref_clk, // system clock
    input  wire logic     srst,    // synchronous reset
    input  wire bfp_cfg_t cfg,     // settings from the loader
    output bfp_cfg_t      taken,   // settings the boot flow acted on
    output logic          moved    // settings changed after being taken
);
    bfp_cfg_t next_taken;
    logic     next_moved;

    // boot flow reads the settings once; it never rereads, so later change is a fault
    always_comb begin
        next_taken = taken;
        next_moved = moved;
        if (srst) begin
            next_taken = '0;
            next_moved = 1'b0;
        end else if (!taken.valid) begin
            next_taken = cfg;
        end else if (cfg !== taken) begin
            next_moved = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        taken <= next_taken;
        moved <= next_moved;
    end
endmodule : bfp_boot_sink

`default_nettype wire

// [dv/bfp_top_test.sv]
`timescale 1ns/10ps
`default_nettype none

module bfp_top_test
    import bfp_pkg::*;
();
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic        autoProbeFuse = 1'b0;
    logic        boot_fuse_select = 1'b0;
    logic [7:0]  boot_config_byte1 = 8'h00;
    logic [31:0] fuseWord = 32'h0;
    logic        probe_enable_strap = 1'b0;
    logic        flash_type_strap0 = 1'b0;
    logic        flash_type_strap1 = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    bfp_cfg_t    cfg;
    bfp_cfg_t    taken;
    logic        bootDone, pready, pslverr, moved;
    logic [31:0] prdata;
    int          miscompares = 0;
    int          testsRun = 0;

    bfp_top DUT (.ref_clk(ref_clk), .srst(srst), .autoProbeFuse(autoProbeFuse),
        .boot_fuse_select(boot_fuse_select), .boot_config_byte1(boot_config_byte1),
        .fuseWord(fuseWord), .probe_enable_strap(probe_enable_strap),
        .flash_type_strap0(flash_type_strap0), .flash_type_strap1(flash_type_strap1),
        .cfg(cfg), .bootDone(bootDone), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr));
    bfp_boot_sink sink (.ref_clk(ref_clk), .srst(srst), .cfg(cfg), .taken(taken), .moved(moved));

    always #20 ref_clk = ~ref_clk;

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic compare(input string what, input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : compare

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    // boot inputs only change under reset; straps are {probe, type1, type0}
    task automatic boot(input logic fs, input logic pf, input logic [7:0] b1,
                        input logic [31:0] fw, input logic [2:0] st);
        int n;
        @(posedge ref_clk); // let the previous capture's checks run first
        srst <= 1'b1;
        boot_fuse_select <= fs;
        autoProbeFuse <= pf;
        boot_config_byte1 <= b1;
        fuseWord <= fw;
        {probe_enable_strap, flash_type_strap1, flash_type_strap0} <= st;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (cfg.valid !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            stop_test();
        end
    endtask : boot

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            miscompares++;
            stop_test();
        end
        @(posedge ref_clk);
    endtask : apb

    function automatic logic [25:0] expSize(input logic [3:0] f, input logic [7:0] o);
        if (f == 4'h0) return 26'(o) * 26'h40000;
        if (f < 4'hd) return 26'(f) * 26'h100000;
        return 26'(f - 4'hc) * 26'h40000;
    endfunction : expSize

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic test_apb();
        logic [31:0] r;
        logic        e;
        boot(1'b1, 1'b0, 8'h00, 32'ha5a5_1234, 3'h0);
        compare("done at reset", 32'(bootDone), 32'h0);
        apb(1'b1, ADDR_FUSE, 32'hffff_ffff, r, e);
        compare("fuse write refused", 32'(e), 32'h1);
        apb(1'b0, ADDR_FUSE, 32'h0, r, e);
        compare("fuse word", r, 32'ha5a5_1234);
        compare("fuse read error", 32'(e), 32'h0);
        apb(1'b0, 12'h700, 32'h0, r, e);
        compare("unmapped error", 32'(e), 32'h1);
        compare("unmapped data", r, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h1, r, e);
        compare("boot done", 32'(bootDone), 32'h1);
        apb(1'b0, ADDR_CTRL, 32'h0, r, e);
        compare("ctrl read", r, 32'h1);
        $display("register test done");
    endtask : test_apb

    // straps set opposite to the fuse type so a mixed-up source shows
    task automatic test_fuse_mode();
        for (int t = 0; t < 4; t++) begin
            boot(1'b1, 1'b1, {4'hf, 2'(t), 2'h3}, 32'h0, {1'b0, ~2'(t)});
            compare("fuse type", 32'(cfg.flashType), 32'(t));
            compare("fuse probe", 32'(cfg.autoProbe), 32'h1);
            compare("fuse mode", 32'(cfg.fuseMode), 32'h1);
        end
        boot(1'b1, 1'b0, 8'h00, 32'h0, 3'h7);
        compare("fuse probe off", 32'(cfg.autoProbe), 32'h0);
        $display("fuse mode test done");
    endtask : test_fuse_mode

    task automatic test_strap_mode();
        for (int i = 0; i < 8; i++) begin
            boot(1'b0, 1'b1, {4'h0, ~2'(i), 2'h0}, 32'h0, 3'(i));
            compare("strap probe", 32'(cfg.autoProbe), 32'(i[2]));
            compare("strap type", 32'(cfg.flashType), 32'(i[1:0]));
        end
        $display("strap mode test done");
    endtask : test_strap_mode

    // every size and dummy code, offset sweeping 0 to 255, then offset-sized image
    task automatic test_fields();
        logic [7:0] o;
        logic [3:0] f;
        for (int i = 0; i < 17; i++) begin
            f = 4'(i);
            o = (i == 16) ? 8'h02 : 8'(i * 17);
            boot(1'b1, 1'b0, 8'h00, {8'hff, o, f, f, 8'hff}, 3'h0);
            compare("offset", 32'(cfg.secImageOffset), {6'h0, o, 18'h0});
            compare("remap", 32'(cfg.remapEn), 32'(o != 8'h00));
            compare("size", 32'(cfg.imageSize), 32'(expSize(f, o)));
            compare("dummy", 32'(cfg.dummyCycles), 32'(f));
            compare("dummy auto", 32'(cfg.dummyAuto), 32'(f == 4'h0));
        end
        $display("field test done");
    endtask : test_fields

    task automatic test_hold();
        bfp_cfg_t    snap;
        logic [31:0] r;
        logic        e;
        boot(1'b1, 1'b1, 8'h04, 32'h0012_3800, 3'h5);
        snap = cfg;
        boot_fuse_select <= 1'b0;
        fuseWord <= 32'h00ff_f000;
        {probe_enable_strap, flash_type_strap1, flash_type_strap0} <= 3'h2;
        repeat (10) @(posedge ref_clk);
        compare("held settings", 32'(cfg !== snap), 32'h0);
        compare("sink moved", 32'(moved), 32'h0);
        compare("sink taken", 32'(taken !== snap), 32'h0);
        apb(1'b0, ADDR_FUSE, 32'h0, r, e);
        compare("captured fuse", r, 32'h0012_3800);
        apb(1'b0, ADDR_OFFSET, 32'h0, r, e);
        compare("offset reg", r, 32'h0048_0000);
        apb(1'b0, ADDR_SIZE, 32'h0, r, e);
        compare("size reg", r, 32'h0030_0000);
        apb(1'b0, ADDR_STATUS, 32'h0, r, e);
        compare("status", r, 32'h0102_082f);
        {probe_enable_strap, flash_type_strap1, flash_type_strap0} <= 3'h5;
        repeat (3) @(posedge ref_clk);
        apb(1'b1, ADDR_STATUS, 32'h0100_0000, r, e);
        apb(1'b0, ADDR_STATUS, 32'h0, r, e);
        compare("change cleared", r, 32'h0005_082f);
        $display("hold test done");
    endtask : test_hold

    initial begin
        test_apb();
        test_fuse_mode();
        test_strap_mode();
        test_fields();
        test_hold();
        stop_test();
    end
endmodule : bfp_top_test

bind bfp_top bfp_top_properties chk (.ref_clk(ref_clk), .srst(srst),
    .autoProbeFuse(autoProbeFuse), .boot_fuse_select(boot_fuse_select),
    .boot_config_byte1(boot_config_byte1), .fuseWord(fuseWord),
    .probe_enable_strap(probe_enable_strap), .flash_type_strap0(flash_type_strap0),
    .flash_type_strap1(flash_type_strap1), .cfg(cfg), .psel(psel), .penable(penable),
    .pready(pready));

`default_nettype wire
